/* dv/fetch_dmem_model.sv */
// far-side model: program word store and data register file
// assumes the executor drives PC and the data strobes from CLK
`timescale 1ns/100ps
module fetch_dmem_model (
    // clock
    input wire logic clk,
    // fetch side
    input wire logic [bit_skip_branch_pkg::PC_W-1:0] pc,
    output logic [bit_skip_branch_pkg::WORD_W-1:0] instr,
    output logic next_two_word,
    // data side
    input wire logic [bit_skip_branch_pkg::ADDR_W-1:0] dmem_addr,
    output logic [bit_skip_branch_pkg::DATA_W-1:0] dmem_rdata,
    input wire logic dmem_we,
    input wire logic [bit_skip_branch_pkg::DATA_W-1:0] dmem_wdata
);
    // ==============================================================
    // storage, loaded by the bench before reset ends
    logic [15:0] prog [64]; // program words, wraps every 64 words
    logic two_word [64]; // marks words that start a two-word instruction
    logic [7:0] dmem [4096]; // full data space, no holes

    // ==============================================================
    // read paths are combinational, as the executor expects
    assign instr = prog[pc[6:1]];
    assign next_two_word = two_word[pc[6:1] + 6'h01];
    assign dmem_rdata = dmem[dmem_addr];

    // write lands on the strobe edge only
    always @(posedge clk) begin
        if (dmem_we) begin
            dmem[dmem_addr] <= dmem_wdata;
        end
    end
endmodule : fetch_dmem_model

/* dv/testbench.sv */
// self-checking bench: random program run against a cycle reference model
// assumes one clock per phase, first clock after reset release is Q1
`timescale 1ns/100ps
module testbench;
    // ==============================================================
    // design-facing signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] instr;
    logic next_two_word, nop_cycle, dmem_we;
    logic flag_ov = 1'b0;
    logic flag_z = 1'b0;
    logic [3:0] bank_sel = 4'h0;
    logic [20:0] pc;
    logic [11:0] dmem_addr, addr, seen_addr;
    logic [7:0] dmem_rdata, dmem_wdata, seen_data, f;
    // reference model state
    logic [7:0] ref_mem [4096]; // own copy, never read back from design
    logic [20:0] m_pc, next_pc;
    logic [15:0] r, w;
    logic m_nop, exp_we, seen_we, bitv;
    int nop_left, i, cyc, fail_count, total_checks, ticks;

    // ==============================================================
    // clock and cycle ceiling
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        ticks++;
        if (ticks == 3000) begin
            fail_count++;
            final_report();
        end
    end

    bit_skip_branch_exec bit_skip_branch_exec_inst (.CLK(clk), .RST_N(rst_n),
        .INSTR(instr), .NEXT_TWO_WORD(next_two_word), .PC(pc), .NOP_CYCLE(nop_cycle),
        .FLAG_OV(flag_ov), .FLAG_Z(flag_z), .BANK_SEL(bank_sel), .DMEM_ADDR(dmem_addr),
        .DMEM_RDATA(dmem_rdata), .DMEM_WE(dmem_we), .DMEM_WDATA(dmem_wdata));
    fetch_dmem_model fetch_dmem_model_inst (.clk(clk), .pc(pc), .instr(instr),
        .next_two_word(next_two_word), .dmem_addr(dmem_addr), .dmem_rdata(dmem_rdata),
        .dmem_we(dmem_we), .dmem_wdata(dmem_wdata));

    // ==============================================================
    // helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic check(input string what, input logic [20:0] exp, input logic [20:0] seen);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    // ==============================================================
    // main sequence: load random program and data, then step cycles
    initial begin
        r = 16'h0018;
        for (i = 0; i < 4096; i++) begin
            r = lfsr(r);
            ref_mem[i] = r[7:0];
            fetch_dmem_model_inst.dmem[i] = r[7:0];
        end
        // opcode mix covers every decoded kind plus unrelated words
        for (i = 0; i < 64; i++) begin
            r = lfsr(r);
            w = lfsr(r);
            case (r[2:0])
                3'h0: w = {4'hb, w[11:0]};
                3'h1: w = {4'ha, w[11:0]};
                3'h2: w = {4'h7, w[11:0]};
                3'h3, 3'h4: w = {8'he4, w[7:0]};
                3'h5: w = {8'he0, w[7:0]};
                default: w = {4'h0, w[11:0]};
            endcase
            fetch_dmem_model_inst.prog[i] = w;
            fetch_dmem_model_inst.two_word[i] = r[5];
        end
        m_pc = 21'h0;
        m_nop = 1'b0;
        nop_left = 0;
        repeat (10) @(posedge clk);
        #2;
        rst_n = 1'b1;
        for (cyc = 0; cyc < 500; cyc++) begin
            // flags and bank held across the Q1 sampling edge
            r = lfsr(r);
            flag_ov = r[0];
            flag_z = r[1];
            bank_sel = r[5:2];
            check("pc", m_pc, pc);
            check("nop_cycle", 21'(m_nop), 21'(nop_cycle));
            seen_we = 1'b0;
            repeat (4) begin
                @(posedge clk);
                #2;
                if (dmem_we === 1'b1) begin
                    seen_we = 1'b1;
                    seen_addr = dmem_addr;
                    seen_data = dmem_wdata;
                end
            end
            // reference step for the cycle just run
            w = fetch_dmem_model_inst.prog[m_pc[6:1]];
            f = w[7:0];
            addr = w[8] ? {bank_sel, f} : {(f[7] ? 4'hf : 4'h0), f};
            bitv = ref_mem[addr][w[11:9]];
            next_pc = m_pc + 21'h2;
            exp_we = 1'b0;
            if (m_nop) begin
                // discarded word: nothing executes
            end else if ((w[15:12] == 4'hb && !bitv) || (w[15:12] == 4'ha && bitv)) begin
                nop_left = fetch_dmem_model_inst.two_word[m_pc[6:1] + 6'h01] ? 2 : 1;
            end else if (w[15:12] == 4'h7) begin
                exp_we = 1'b1;
                ref_mem[addr][w[11:9]] = !bitv;
            end else if ((w[15:8] == 8'he4 && flag_ov) || (w[15:8] == 8'he0 && flag_z)) begin
                next_pc = next_pc + {{12{f[7]}}, f, 1'b0};
                nop_left = 1;
            end
            check("dmem_we", {20'h0, exp_we}, {20'h0, seen_we});
            if (exp_we) begin
                check("dmem_addr", {9'h0, addr}, {9'h0, seen_addr});
                check("dmem_wdata", {13'h0, ref_mem[addr]}, {13'h0, seen_data});
            end
            m_pc = next_pc;
            m_nop = (nop_left > 0);
            if (m_nop) begin
                nop_left--;
            end
        end
        $display("test random_program done after %0d cycles", cyc);
        final_report();
    end
endmodule : testbench

/* rtl/bit_skip_branch_exec.sv */
// executor for bit skip, bit invert and overflow/zero relative branches
// assumes INSTR holds the word at PC, readable data memory and fetch path
// takes NEXT_TWO_WORD to learn whether the prefetched next word is a two-word instruction
`timescale 1ns/100ps
module bit_skip_branch_exec (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // fetch path
    input wire logic [bit_skip_branch_pkg::WORD_W-1:0] INSTR,
    input wire logic NEXT_TWO_WORD,
    output logic [bit_skip_branch_pkg::PC_W-1:0] PC,
    output logic NOP_CYCLE,
    // status and bank inputs
    input wire logic FLAG_OV,
    input wire logic FLAG_Z,
    input wire logic [bit_skip_branch_pkg::BANK_W-1:0] BANK_SEL,
    // data memory
    output logic [bit_skip_branch_pkg::ADDR_W-1:0] DMEM_ADDR,
    input wire logic [bit_skip_branch_pkg::DATA_W-1:0] DMEM_RDATA,
    output logic DMEM_WE,
    output logic [bit_skip_branch_pkg::DATA_W-1:0] DMEM_WDATA
);
    // ==================================================================
    // helper functions

    // data address from access bit, file byte and bank register
    function automatic logic [bit_skip_branch_pkg::ADDR_W-1:0] data_addr(
        input logic acc,
        input logic [7:0] f,
        input logic [bit_skip_branch_pkg::BANK_W-1:0] bank
    );
        if (acc) begin
            data_addr = {bank, f};
        end else if (f < bit_skip_branch_pkg::ACCESS_SPLIT) begin
            data_addr = {bit_skip_branch_pkg::ACCESS_LOW_BANK, f};
        end else begin
            data_addr = {bit_skip_branch_pkg::ACCESS_HIGH_BANK, f};
        end
    endfunction : data_addr

    // true for the bit-oriented opcodes handled here
    function automatic logic is_bit_op(input logic [3:0] opc);
        is_bit_op = (opc == bit_skip_branch_pkg::OP_SKIP_CLR) ||
                    (opc == bit_skip_branch_pkg::OP_SKIP_SET) ||
                    (opc == bit_skip_branch_pkg::OP_BIT_INV);
    endfunction : is_bit_op

    // ==================================================================
    // phase enables
    logic [bit_skip_branch_pkg::PHASES-1:0] q_en; // one-hot phase
    logic q1; // decode phase
    logic q3; // process phase
    logic q4; // write phase

    q_phase_gen u_phase (
        .clk(CLK),
        .rst_n(RST_N),
        .q_en(q_en)
    );

    assign q1 = q_en[0];
    assign q3 = q_en[2];
    assign q4 = q_en[3];

    // ==================================================================
    // executor state
    bit_skip_branch_pkg::exec_type state, next_state; // run or dropping
    logic [bit_skip_branch_pkg::WORD_W-1:0] ir, next_ir; // latched word
    logic ov_q, next_ov_q; // overflow at cycle start
    logic z_q, next_z_q; // zero at cycle start
    logic [bit_skip_branch_pkg::DATA_W-1:0] rdata, next_rdata; // operand
    logic [bit_skip_branch_pkg::PC_W-1:0] next_pc;
    logic next_nop;
    logic [bit_skip_branch_pkg::ADDR_W-1:0] next_addr;
    logic next_we;
    logic [bit_skip_branch_pkg::DATA_W-1:0] next_wdata;

    // decoded fields of the latched word
    logic [3:0] opc; // top nibble
    logic [7:0] br_opc; // branch opcode byte
    logic [2:0] bsel; // bit number
    logic [bit_skip_branch_pkg::DATA_W-1:0] mask; // selected bit
    logic tested; // selected operand bit
    logic skip; // skip condition met
    logic take; // branch condition met
    logic [bit_skip_branch_pkg::PC_W-1:0] disp; // doubled offset

    always_comb begin
        opc = ir[bit_skip_branch_pkg::OPC_HI:bit_skip_branch_pkg::OPC_LO];
        br_opc = ir[bit_skip_branch_pkg::BR_HI:bit_skip_branch_pkg::BR_LO];
        bsel = ir[bit_skip_branch_pkg::BIT_HI:bit_skip_branch_pkg::BIT_LO];
        mask = 8'h01 << bsel;
        tested = |(rdata & mask);
        skip = ((opc == bit_skip_branch_pkg::OP_SKIP_CLR) && !tested) ||
               ((opc == bit_skip_branch_pkg::OP_SKIP_SET) && tested);
        take = ((br_opc == bit_skip_branch_pkg::OP_BR_OV) && ov_q) ||
               ((br_opc == bit_skip_branch_pkg::OP_BR_ZERO) && z_q);
        // sign extend and double the offset
        disp = {{(bit_skip_branch_pkg::PC_W-9){ir[bit_skip_branch_pkg::OFF_HI]}},
                ir[bit_skip_branch_pkg::OFF_HI:0], 1'b0};
    end

    // ==================================================================
    // next-value logic for the whole executor
    always_comb begin
        next_state = state;
        next_ir = ir;
        next_ov_q = ov_q;
        next_z_q = z_q;
        next_rdata = rdata;
        next_pc = PC;
        next_nop = NOP_CYCLE;
        next_addr = DMEM_ADDR;
        next_we = 1'b0; // write strobe lasts only the write phase
        next_wdata = DMEM_WDATA;
        if (q1) begin
            // decode: latch the word and the flags as the cycle opens
            next_ir = INSTR;
            next_ov_q = FLAG_OV;
            next_z_q = FLAG_Z;
            if (state == bit_skip_branch_pkg::ST_RUN &&
                    is_bit_op(INSTR[bit_skip_branch_pkg::OPC_HI:
                                    bit_skip_branch_pkg::OPC_LO])) begin
                next_addr = data_addr(INSTR[bit_skip_branch_pkg::ACC_POS],
                                      INSTR[bit_skip_branch_pkg::F_HI:0], BANK_SEL);
            end
        end
        if (q3) begin
            // process: sample operand, prepare write for the invert
            next_rdata = DMEM_RDATA;
            if (state == bit_skip_branch_pkg::ST_RUN &&
                    opc == bit_skip_branch_pkg::OP_BIT_INV) begin
                next_we = 1'b1;
                next_wdata = DMEM_RDATA ^ mask;
            end
        end
        if (q4) begin
            // write phase: move the pc and pick the next cycle's kind
            next_pc = PC + bit_skip_branch_pkg::PC_STEP;
            next_state = bit_skip_branch_pkg::ST_RUN;
            unique case (state)
                bit_skip_branch_pkg::ST_RUN: begin
                    if (skip) begin
                        // discarded words still advance the pc
                        if (NEXT_TWO_WORD) begin
                            next_state = bit_skip_branch_pkg::ST_DROP_TWO;
                        end else begin
                            next_state = bit_skip_branch_pkg::ST_DROP_ONE;
                        end
                    end else if (take) begin
                        next_pc = PC + bit_skip_branch_pkg::PC_STEP + disp;
                        next_state = bit_skip_branch_pkg::ST_DROP_ONE;
                    end
                end
                bit_skip_branch_pkg::ST_DROP_TWO: begin
                    next_state = bit_skip_branch_pkg::ST_DROP_ONE;
                end
                bit_skip_branch_pkg::ST_DROP_ONE: begin
                    next_state = bit_skip_branch_pkg::ST_RUN;
                end
                default: begin
                    next_state = bit_skip_branch_pkg::ST_RUN; // unused code
                end
            endcase
            next_nop = (next_state != bit_skip_branch_pkg::ST_RUN);
        end
    end

    // register the executor
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state <= bit_skip_branch_pkg::ST_RUN;
            ir <= '0;
            ov_q <= 1'b0;
            z_q <= 1'b0;
            rdata <= '0;
            PC <= bit_skip_branch_pkg::PC_RESET;
            NOP_CYCLE <= 1'b0;
            DMEM_ADDR <= '0;
            DMEM_WE <= 1'b0;
            DMEM_WDATA <= '0;
        end else begin
            state <= next_state;
            ir <= next_ir;
            ov_q <= next_ov_q;
            z_q <= next_z_q;
            rdata <= next_rdata;
            PC <= next_pc;
            NOP_CYCLE <= next_nop;
            DMEM_ADDR <= next_addr;
            DMEM_WE <= next_we;
            DMEM_WDATA <= next_wdata;
        end
    end

    // ==================================================================
    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    a_skip_clear_one: assert property (
        (q4 && state == bit_skip_branch_pkg::ST_RUN && opc == bit_skip_branch_pkg::OP_SKIP_CLR
         && !tested && !NEXT_TWO_WORD) |=> NOP_CYCLE [*4] ##1 !NOP_CYCLE)
        else $error("clear-bit skip did not drop one word");
    a_skip_set_none: assert property (
        (q4 && state == bit_skip_branch_pkg::ST_RUN && !skip && !take) |=> !NOP_CYCLE [*4])
        else $error("nop cycle without skip or branch");
    a_skip_two_words: assert property (
        (q4 && state == bit_skip_branch_pkg::ST_RUN && skip && NEXT_TWO_WORD)
        |=> NOP_CYCLE [*8] ##1 !NOP_CYCLE)
        else $error("two-word skip did not drop two words");
    a_access_bank: assert property (
        (q1 && state == bit_skip_branch_pkg::ST_RUN && !INSTR[bit_skip_branch_pkg::ACC_POS]
         && is_bit_op(INSTR[bit_skip_branch_pkg::OPC_HI:bit_skip_branch_pkg::OPC_LO]))
        |=> DMEM_ADDR[11:8] == (DMEM_ADDR[7] ? bit_skip_branch_pkg::ACCESS_HIGH_BANK
                                             : bit_skip_branch_pkg::ACCESS_LOW_BANK))
        else $error("access bank not forced");
    a_bank_reg_used: assert property (
        (q1 && state == bit_skip_branch_pkg::ST_RUN && INSTR[bit_skip_branch_pkg::ACC_POS]
         && is_bit_op(INSTR[bit_skip_branch_pkg::OPC_HI:bit_skip_branch_pkg::OPC_LO]))
        |=> DMEM_ADDR[11:8] == $past(BANK_SEL))
        else $error("bank register ignored");
    a_invert_one_bit: assert property (
        DMEM_WE |-> q4 && $onehot(DMEM_WDATA ^ rdata))
        else $error("invert wrote more than one bit or off phase");
    a_branch_target: assert property (
        (q4 && state == bit_skip_branch_pkg::ST_RUN && !skip && take)
        |=> PC == $past(PC) + bit_skip_branch_pkg::PC_STEP
                  + 21'(2 * $signed($past(ir[bit_skip_branch_pkg::OFF_HI:0])))
        ##1 NOP_CYCLE [*3])
        else $error("taken branch target or nop wrong");
    a_branch_untaken: assert property (
        (q4 && state == bit_skip_branch_pkg::ST_RUN && !skip && !take)
        |=> PC == $past(PC) + bit_skip_branch_pkg::PC_STEP)
        else $error("untaken branch did not continue");
    a_flag_sample: assert property (
        q1 |=> ov_q == $past(FLAG_OV) && z_q == $past(FLAG_Z) ##1 $stable(ov_q) [*3])
        else $error("flags not held from cycle start");
endmodule : bit_skip_branch_exec

/* rtl/bit_skip_branch_pkg.sv */
// constants, opcodes and field positions for the bit, skip and branch executor
// assumes a four-phase instruction cycle, one clock per phase
// Function
// - skip next word when tested bit clear
// - taken skip discards prefetch, runs one nop
// - skip over two-word instruction costs three cycles
// - access bit picks fixed bank or bank register
// - bit invert flips one bit, flags untouched
// - overflow branch taken only when overflow set
// - target is pc plus two plus twice offset
// - taken branch two cycles, untaken one cycle
// - untaken branch continues at following word
// - zero branch taken only when zero set
package bit_skip_branch_pkg;
    // ==================================================================
    // widths
    localparam int PC_W = 21;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int WORD_W = 16;
    localparam int BANK_W = 4;
    localparam int PHASES = 4;

    // ==================================================================
    // instruction word fields
    localparam int OPC_HI = 15;
    localparam int OPC_LO = 12;
    localparam int BIT_HI = 11;
    localparam int BIT_LO = 9;
    localparam int ACC_POS = 8;
    localparam int F_HI = 7;
    localparam int BR_HI = 15;
    localparam int BR_LO = 8;
    localparam int OFF_HI = 7;

    // ==================================================================
    // opcodes
    localparam logic [3:0] OP_SKIP_CLR = 4'hb;
    localparam logic [3:0] OP_SKIP_SET = 4'ha;
    localparam logic [3:0] OP_BIT_INV = 4'h7;
    localparam logic [7:0] OP_BR_OV = 8'he4;
    localparam logic [7:0] OP_BR_ZERO = 8'he0;

    // ==================================================================
    // access bank split and reset values
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [PHASES-1:0] PHASE_FIRST = 4'h1;

    // executor states
    typedef enum logic [1:0] {ST_RUN, ST_DROP_ONE, ST_DROP_TWO} exec_type;
endpackage : bit_skip_branch_pkg

/* rtl/q_phase_gen.sv */
// four-phase enable generator for the instruction cycle
// assumes one clock per phase; outputs exactly one pulse per clock
`timescale 1ns/100ps
module q_phase_gen (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // one-hot phase enables, bit 0 is the decode phase
    output logic [bit_skip_branch_pkg::PHASES-1:0] q_en
);
    // ==================================================================
    // rotating one-hot ring
    logic [bit_skip_branch_pkg::PHASES-1:0] next_q_en; // rotated ring

    // rotate left every clock
    always_comb begin
        next_q_en = {q_en[bit_skip_branch_pkg::PHASES-2:0],
                     q_en[bit_skip_branch_pkg::PHASES-1]};
    end

    // register, restart at decode phase
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q_en <= bit_skip_branch_pkg::PHASE_FIRST;
        end else begin
            q_en <= next_q_en;
        end
    end
endmodule : q_phase_gen
